// >>> include/pcm_pkg.sv
package pcm_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 18;
  localparam logic [17:0] IDX_DATA  = 18'h0f252;
  localparam logic [17:0] IDX_DIR   = 18'h0f253;
  localparam logic [17:0] IDX_DRVL  = 18'h0f254;
  localparam logic [17:0] IDX_DRVH  = 18'h0f255;
  localparam logic [17:0] IDX_FUNL  = 18'h0f256;
  localparam logic [17:0] IDX_FUNH  = 18'h0f257;
  localparam logic [17:0] ADR_DATA  = {IDX_DATA[15:0], 2'h0};
  localparam logic [17:0] ADR_DIR   = {IDX_DIR[15:0], 2'h0};
  localparam logic [17:0] ADR_DRVL  = {IDX_DRVL[15:0], 2'h0};
  localparam logic [17:0] ADR_DRVH  = {IDX_DRVH[15:0], 2'h0};
  localparam logic [17:0] ADR_FUNL  = {IDX_FUNL[15:0], 2'h0};
  localparam logic [17:0] ADR_FUNH  = {IDX_FUNH[15:0], 2'h0};
  localparam logic [7:0]  RST_REG   = 8'h00;
  localparam int          NPIN      = 8;
  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  DRV_OFF   = 2'h0;
  localparam logic [1:0]  DRV_PCH   = 2'h1;
  localparam logic [1:0]  DRV_NCH   = 2'h2;
  localparam logic [1:0]  DRV_PP    = 2'h3;
  localparam logic [1:0]  FN_GP     = 2'h0;
  localparam logic [1:0]  FN_A      = 2'h1;
  localparam logic [1:0]  FN_B      = 2'h2;
  localparam logic [1:0]  FN_C      = 2'h3;
  // Per code: pins where the code is unused
  localparam logic [7:0]  RSV_A     = 8'hc0;
  localparam logic [7:0]  RSV_B     = 8'h10;
  localparam logic [7:0]  RSV_C     = 8'h5f;
  // Per code: pins where the code only feeds a peripheral input
  localparam logic [7:0]  INP_A     = 8'h14;
  localparam logic [7:0]  INP_B     = 8'h21;
  // Pin indices of routed functions
  localparam int          P_SDA     = 0;
  localparam int          P_SCL     = 1;
  localparam int          P_RXB     = 2;
  localparam int          P_RXA     = 4;
  localparam int          P_SINH    = 5;
  localparam int          P_SCKH    = 6;
endpackage : pcm_pkg

// >>> logic/pcm_port_mux.sv
// The APB register port was decided locally.
`timescale 1ns/100ps
module pcm_port_mux
  import pcm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        en_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [17:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_n_out,
  output logic      [7:0]  pull_up_out,
  output logic      [7:0]  pull_down_out,
  // Peripheral outputs toward the pins
  input  wire logic        uart_a_transmit_in,
  input  wire logic        uart_b_transmit_in,
  input  wire logic        sync_serial_data_out_in,
  input  wire logic        sync_serial_clock_in,
  input  wire logic        i2c_scl_in,
  input  wire logic        i2c_sda_in,
  input  wire logic        pulse_width_out_a_in,
  input  wire logic        pulse_width_out_b_in,
  // Pin levels toward the peripherals
  output logic             uart_a_receive_out,
  output logic             uart_b_receive_out,
  output logic             sync_serial_data_in_out,
  output logic             sync_serial_clock_out,
  output logic             i2c_scl_out,
  output logic             i2c_sda_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] drvl_q;
  logic [7:0] drvh_q;
  logic [7:0] funl_q;
  logic [7:0] funh_q;
  logic [7:0] pin_q;
  logic [7:0] rd_data;
  logic [7:0] alt_a;
  logic [7:0] alt_b;
  logic [7:0] alt_c;
  logic [7:0] pin_val;
  logic [7:0] oe_n_d;
  logic       acc;
  logic       wr;
  logic       hit;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Access takes two cycles: pready is raised one edge into access.
  assign acc = psel_in && penable_in;
  assign wr  = acc && pready_out && pwrite_in && pstrb_in[0] && hit;

  always_comb begin
    hit = 1'b1;
    case (paddr_in)
      ADR_DATA: rd_data = (dir_q & pin_q) | (~dir_q & data_q);
      ADR_DIR:  rd_data = dir_q;
      ADR_DRVL: rd_data = drvl_q;
      ADR_DRVH: rd_data = drvh_q;
      ADR_FUNL: rd_data = funl_q;
      ADR_FUNH: rd_data = funh_q;
      default: begin
        rd_data = 8'h00;
        hit     = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (en_in) begin
      pready_out <= acc && !pready_out;
      if (acc && !pready_out) begin
        prdata_out  <= {24'h00_0000, pwrite_in ? 8'h00 : rd_data};
        pslverr_out <= !hit;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      data_q <= RST_REG;
      dir_q  <= RST_REG;
      drvl_q <= RST_REG;
      drvh_q <= RST_REG;
      funl_q <= RST_REG;
      funh_q <= RST_REG;
    end else if (en_in && wr) begin
      case (paddr_in)
        ADR_DATA: data_q <= pwdata_in[7:0];
        ADR_DIR:  dir_q  <= pwdata_in[7:0];
        ADR_DRVL: drvl_q <= pwdata_in[7:0];
        ADR_DRVH: drvh_q <= pwdata_in[7:0];
        ADR_FUNL: funl_q <= pwdata_in[7:0];
        ADR_FUNH: funh_q <= pwdata_in[7:0];
        default:  data_q <= data_q;
      endcase
    end
  end

  // Pins are synchronous to the clock; one sample stage
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pin_q <= 8'h00;
    end else if (en_in) begin
      pin_q <= pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Function routing
  // ----------------------------------------------------------------
  // Serial clock is routed as an output value; under code B the level of pin 6,
  // else of pin 1, also goes to the serial unit, whether the pin is input or output.
  assign alt_a = {2'b00, uart_a_transmit_in, 1'b0,
                  uart_b_transmit_in, 1'b0, i2c_scl_in,
                  i2c_sda_in};
  assign alt_b = {sync_serial_data_out_in, sync_serial_clock_in, 1'b0,
                  1'b0, pulse_width_out_a_in, sync_serial_data_out_in,
                  sync_serial_clock_in, 1'b0};
  assign alt_c = {pulse_width_out_b_in, 1'b0, uart_b_transmit_in,
                  5'b00000};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
      logic [1:0] fn;
      logic [1:0] dv;
      assign fn = {funh_q[i], funl_q[i]};
      assign dv = {drvh_q[i], drvl_q[i]};

      always_comb begin
        case (fn)
          FN_GP: pin_val[i] = data_q[i];
          FN_A: begin
            if (RSV_A[i])
              pin_val[i] = 1'b0;
            else if (INP_A[i])
              pin_val[i] = data_q[i];
            else
              pin_val[i] = alt_a[i];
          end
          FN_B: begin
            if (RSV_B[i])
              pin_val[i] = 1'b0;
            else if (INP_B[i])
              pin_val[i] = data_q[i];
            else
              pin_val[i] = alt_b[i];
          end
          FN_C: begin
            if (RSV_C[i])
              pin_val[i] = 1'b0;
            else
              pin_val[i] = alt_c[i];
          end
          default: pin_val[i] = data_q[i];
        endcase
      end

      // Open-drain types only drive the level they own
      always_comb begin
        case (dv)
          DRV_OFF: oe_n_d[i] = 1'b1;
          DRV_PCH: oe_n_d[i] = !pin_val[i];
          DRV_NCH: oe_n_d[i] = pin_val[i];
          DRV_PP:  oe_n_d[i] = 1'b0;
          default: oe_n_d[i] = 1'b1;
        endcase
      end

      always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
          pin_out[i]       <= 1'b0;
          pin_oe_n_out[i]  <= 1'b1;
          pull_up_out[i]   <= 1'b0;
          pull_down_out[i] <= 1'b0;
        end else if (en_in) begin
          pin_out[i]       <= pin_val[i];
          pin_oe_n_out[i]  <= dir_q[i] | oe_n_d[i];
          pull_up_out[i]   <= dir_q[i] && dv == DRV_NCH;
          pull_down_out[i] <= dir_q[i] && dv == DRV_PCH;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin levels to peripherals
  // ----------------------------------------------------------------
  // Unrouted inputs rest at their idle level so a peripheral sees
  // no false start bit or clock edge.
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      uart_a_receive_out      <= 1'b1;
      uart_b_receive_out      <= 1'b1;
      sync_serial_data_in_out <= 1'b0;
      sync_serial_clock_out   <= 1'b0;
      i2c_scl_out             <= 1'b1;
      i2c_sda_out             <= 1'b1;
    end else if (en_in) begin
      uart_a_receive_out <= ({funh_q[P_RXA], funl_q[P_RXA]} == FN_A) ?
                            pin_q[P_RXA] : 1'b1;
      uart_b_receive_out <= ({funh_q[P_RXB], funl_q[P_RXB]} == FN_A) ?
                            pin_q[P_RXB] : 1'b1;
      if ({funh_q[P_SINH], funl_q[P_SINH]} == FN_B)
        sync_serial_data_in_out <= pin_q[P_SINH];
      else if ({funh_q[P_SDA], funl_q[P_SDA]} == FN_B)
        sync_serial_data_in_out <= pin_q[P_SDA];
      else
        sync_serial_data_in_out <= 1'b0;
      if ({funh_q[P_SCKH], funl_q[P_SCKH]} == FN_B)
        sync_serial_clock_out <= pin_q[P_SCKH];
      else if ({funh_q[P_SCL], funl_q[P_SCL]} == FN_B)
        sync_serial_clock_out <= pin_q[P_SCL];
      else
        sync_serial_clock_out <= 1'b0;
      i2c_scl_out <= ({funh_q[P_SCL], funl_q[P_SCL]} == FN_A) ?
                     pin_q[P_SCL] : 1'b1;
      i2c_sda_out <= ({funh_q[P_SDA], funl_q[P_SDA]} == FN_A) ?
                     pin_q[P_SDA] : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_wr_dir;
    en_in && wr && paddr_in == ADR_DIR;
  endsequence

  sequence s_rd_setup;
    en_in && acc && !pready_out && !pwrite_in && paddr_in == ADR_DATA;
  endsequence

  property p_dir_reset;
    $rose(nrst_in) |-> dir_q == 8'h00 && pin_oe_n_out == 8'hff;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("pins not released after reset");

  property p_dir_write;
    s_wr_dir |=> dir_q == $past(pwdata_in[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write lost");

  property p_hiz_out;
    en_in && !dir_q[0] && drvh_q[0] == 1'b0 && drvl_q[0] == 1'b0
      |=> pin_oe_n_out[0];
  endproperty
  a_hiz_out: assert property (p_hiz_out)
    else $error("off driver is driving");

  property p_push_pull;
    en_in && !dir_q[7] && drvh_q[7] && drvl_q[7] && !funh_q[7]
      && !funl_q[7]
      |=> !pin_oe_n_out[7] && pin_out[7] == $past(data_q[7]);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull pin not following data");

  property p_pull_up;
    en_in && dir_q[3] && drvh_q[3] && !drvl_q[3]
      |=> pull_up_out[3] && !pull_down_out[3] && pin_oe_n_out[3];
  endproperty
  a_pull_up: assert property (p_pull_up)
    else $error("input pull-up not selected");

  property p_read_pin;
    s_rd_setup ##0 (dir_q[2] && !data_q[2] && pin_q[2])
      |=> pready_out && prdata_out[2];
  endproperty
  a_read_pin: assert property (p_read_pin)
    else $error("data read does not show pin level");

  property p_reserved_low;
    en_in && !dir_q[7] && drvh_q[7] && drvl_q[7] && !funh_q[7]
      && funl_q[7]
      |=> !pin_oe_n_out[7] && !pin_out[7];
  endproperty
  a_reserved_low: assert property (p_reserved_low)
    else $error("unused code did not force low");

  property p_uart_tx;
    en_in && !dir_q[5] && drvh_q[5] && drvl_q[5] && !funh_q[5]
      && funl_q[5]
      |=> pin_out[5] == $past(uart_a_transmit_in) && !pin_oe_n_out[5];
  endproperty
  a_uart_tx: assert property (p_uart_tx)
    else $error("UART A transmit not on pin 5");

  property p_uart_rx;
    en_in && !funh_q[4] && funl_q[4]
      |=> uart_a_receive_out == $past(pin_q[4]);
  endproperty
  a_uart_rx: assert property (p_uart_rx)
    else $error("pin 4 not routed to UART A receive");

  property p_nch_high;
    en_in && !dir_q[0] && drvh_q[0] && !drvl_q[0] && !funh_q[0]
      && !funl_q[0] && data_q[0]
      |=> pin_oe_n_out[0];
  endproperty
  a_nch_high: assert property (p_nch_high)
    else $error("open-drain low driver drives high");

  property p_pull_down;
    en_in && dir_q[2] && !drvh_q[2] && drvl_q[2]
      |=> pull_down_out[2] && !pull_up_out[2] && pin_oe_n_out[2];
  endproperty
  a_pull_down: assert property (p_pull_down)
    else $error("input pull-down not selected");

  property p_sck_in;
    en_in && funh_q[6] && !funl_q[6]
      |=> sync_serial_clock_out == $past(pin_q[6]);
  endproperty
  a_sck_in: assert property (p_sck_in)
    else $error("pin 6 not routed to serial clock");

endmodule : pcm_port_mux

// >>> verif/pcm_board_model.sv
`timescale 1ns/100ps
module pcm_board_model (
  // Device side
  input  wire logic       clock_in,
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] oe_n_in,
  input  wire logic [7:0] pull_up_in,
  input  wire logic [7:0] pull_down_in,
  // Board drivers
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_val_in,
  output logic      [7:0] level_out
);
  // Floating wire wanders, never a stable level
  logic [7:0] wander_q = 8'h5a;
  always_ff @(posedge clock_in) begin
    wander_q <= ~wander_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_in[i]) level_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pull_up_in[i]) level_out[i] = 1'b1;
      else if (pull_down_in[i]) level_out[i] = 1'b0;
      else level_out[i] = wander_q[i];
    end
  end
endmodule : pcm_board_model

// >>> verif/pcm_port_mux_bench.sv
`timescale 1ns/100ps
module pcm_port_mux_bench;
  import pcm_pkg::*;
  // ------------------------------------------------
  // Design and board
  // ------------------------------------------------
  localparam logic [17:0] ADR [6] = '{ADR_DATA, ADR_DIR,
    ADR_DRVL, ADR_DRVH, ADR_FUNL, ADR_FUNH};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [17:0] padr = '0;
  logic [31:0] pwd = '0;
  logic [3:0]  pstb = '0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic [7:0]  lvl, pout, poe_n, pup, pdn;
  logic [7:0]  pv = 8'h00;
  logic [7:0]  ext_en = 8'h00;
  logic [7:0]  ext_val = 8'h00;
  logic [5:0]  rx;
  logic [7:0]  sh [6] = '{default: 8'h00};
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  pcm_port_mux dut (.clock_in(clk), .nrst_in(rst_n), .en_in(en),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(padr), .pwdata_in(pwd), .pstrb_in(pstb),
    .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
    .pin_in(lvl), .pin_out(pout), .pin_oe_n_out(poe_n),
    .pull_up_out(pup), .pull_down_out(pdn),
    .i2c_sda_in(pv[0]), .i2c_scl_in(pv[1]),
    .sync_serial_clock_in(pv[2]), .sync_serial_data_out_in(pv[3]),
    .uart_b_transmit_in(pv[4]), .pulse_width_out_a_in(pv[5]),
    .uart_a_transmit_in(pv[6]), .pulse_width_out_b_in(pv[7]),
    .uart_a_receive_out(rx[5]), .uart_b_receive_out(rx[4]),
    .sync_serial_data_in_out(rx[3]), .sync_serial_clock_out(rx[2]),
    .i2c_scl_out(rx[1]), .i2c_sda_out(rx[0]));
  pcm_board_model board (.clock_in(clk), .pin_out_in(pout),
    .oe_n_in(poe_n), .pull_up_in(pup), .pull_down_in(pdn),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] a,
      input logic [7:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, d};
    pstb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (n == 20) begin
      error_cnt++;
      give_verdict();
    end
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input int k, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ADR[k], d, 4'hf, r, e);
    sh[k] = d;
  endtask : wr
  task automatic rdchk(input logic [17:0] a, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, 4'h0, r, e);
    chk(r, {24'h0, x});
  endtask : rdchk
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  // Returns {reserved, value} for pin i under function f
  function automatic logic [1:0] src(int i, logic [1:0] f, logic d);
    case ({i[2:0], f})
      5'h01: return {1'b0, pv[0]};
      5'h05: return {1'b0, pv[1]};
      5'h06, 5'h1a: return {1'b0, pv[2]};
      5'h0a, 5'h1e: return {1'b0, pv[3]};
      5'h0d, 5'h17: return {1'b0, pv[4]};
      5'h0e: return {1'b0, pv[5]};
      5'h15: return {1'b0, pv[6]};
      5'h1f: return {1'b0, pv[7]};
      5'h03, 5'h07, 5'h0b, 5'h0f, 5'h12, 5'h13, 5'h19, 5'h1b,
        5'h1d: return 2'h2;
      default: return {1'b0, d};
    endcase
  endfunction : src
  task automatic chk_pins();
    logic [7:0] oe, po, pu, pd;
    logic [1:0] dv, s;
    for (int i = 0; i < 8; i++) begin
      dv = {sh[3][i], sh[2][i]};
      s = src(i, {sh[5][i], sh[4][i]}, sh[0][i]);
      pu[i] = sh[1][i] && dv == 2'h2;
      pd[i] = sh[1][i] && dv == 2'h1;
      po[i] = s[0] && !s[1];
      oe[i] = sh[1][i] || dv == 2'h0 || dv == {po[i], ~po[i]};
    end
    chk({24'h0, poe_n}, {24'h0, oe});
    chk({24'h0, pout & ~oe}, {24'h0, po & ~oe});
    chk({16'h0, pup, pdn}, {16'h0, pu, pd});
  endtask : chk_pins
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset();
    for (int k = 0; k < 6; k++) rdchk(ADR[k], 8'h00);
    chk_pins();
    $display("reset test done");
  endtask : t_reset
  task automatic t_apb();
    logic [31:0] r;
    logic e;
    apb(1'b1, ADR_FUNH + 18'h4, 8'hff, 4'hf, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, ADR_FUNH + 18'h4, 8'h00, 4'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Strobe low must leave the register alone
    apb(1'b1, ADR[1], 8'hff, 4'h0, r, e);
    rdchk(ADR[1], 8'h00);
    $display("bus test done");
  endtask : t_apb
  task automatic t_out();
    for (int c = 0; c < 4; c++) begin
      wr(2, {8{c[0]}});
      wr(3, {8{c[1]}});
      for (int k = 0; k < 2; k++) begin
        wr(0, k ? 8'h5a : 8'ha5);
        settle();
        chk_pins();
        rdchk(ADR[0], sh[0]);
      end
    end
    $display("output test done");
  endtask : t_out
  task automatic t_in();
    wr(1, 8'hff);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    for (int c = 0; c < 4; c++) begin
      wr(2, {8{c[0]}});
      wr(3, {8{c[1]}});
      settle();
      chk_pins();
      rdchk(ADR[0], 8'h3c);
    end
    ext_en <= 8'h0f;
    wr(1, 8'h0f);
    settle();
    rdchk(ADR[0], {sh[0][7:4], 4'hc});
    $display("input test done");
  endtask : t_in
  task automatic t_fun();
    ext_en <= 8'h00;
    wr(1, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(4, {8{f[0]}});
      wr(5, {8{f[1]}});
      for (int c = 1; c < 4; c++) begin
        wr(2, {8{c[0]}});
        wr(3, {8{c[1]}});
        for (int k = 0; k < 2; k++) begin
          pv <= k ? 8'haa : 8'h55;
          wr(0, k ? 8'h00 : 8'hff);
          settle();
          chk_pins();
        end
      end
    end
    for (int k = 1; k < 6; k++) rdchk(ADR[k], sh[k]);
    $display("function test done");
  endtask : t_fun
  task automatic t_route();
    logic [7:0] v;
    logic [5:0] x;
    wr(1, 8'hff);
    wr(4, 8'h17);
    wr(5, 8'h60);
    ext_en <= 8'hff;
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'haa : 8'h55;
      ext_val <= v;
      settle();
      x = {v[4], v[2], v[5], v[6], v[1], v[0]};
      chk({26'h0, rx}, {26'h0, x});
    end
    // Enable low must freeze the routed levels
    en <= 1'b0;
    ext_val <= ~v;
    settle();
    chk({26'h0, rx}, {26'h0, x});
    en <= 1'b1;
    wr(4, 8'h00);
    wr(5, 8'h03);
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'haa : 8'h55;
      ext_val <= v;
      settle();
      chk({26'h0, rx}, {26'h0, 2'h3, v[0], v[1], 2'h3});
    end
    wr(5, 8'h00);
    settle();
    chk({26'h0, rx}, {26'h0, 6'h33});
    $display("routing test done");
  endtask : t_route
  task automatic t_rerst();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    sh = '{default: 8'h00};
    @(posedge clk);
    t_reset();
    chk({26'h0, rx}, {26'h0, 6'h33});
  endtask : t_rerst
  // ------------------------------------------------
  // Run
  // ------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_apb();
    t_out();
    t_in();
    t_fun();
    t_route();
    t_rerst();
    give_verdict();
  end
endmodule : pcm_port_mux_bench
